// file: wbc_top.sv
// watchdog boot configuration decoder and watchdog core
//
// Overview of operation
// [RULE1] window field selects 25/37.5/50/75 percent
// [RULE2] hardware enable forces watchdog permanently on
// [RULE3] hardware enable clear: off, software may start
// [RULE4] window disable bit selects non-windowed mode
// [RULE5] postscale ratio is two to code power
// [RULE6] codes above maximum behave as maximum
// [RULE7] programmer writes ones into reserved bits
// [RULE8] window bits 25:24, postscale bits 20:16
// [RULE9] fields latched at reset, constant afterward
`timescale 1ns/1ps
`include "wbc_consts.svh"

module wbc_top #(
    parameter int TICK_BITS = 8
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [31:0] CFG_WORD,
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [31:0]      RDATA,
    output logic             WDT_ON,
    output logic             WIN_OPEN,
    output logic             WDT_TIMEOUT
);

    initial begin
        if (TICK_BITS < 2 || TICK_BITS > 8) begin
            $error("TICK_BITS out of range");
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [4:0] clamp_ps(input logic [4:0] c);
        clamp_ps = (c > `WBC_PS_MAX) ? `WBC_PS_MAX : c;
    endfunction

    function automatic logic [3:0] win_eighths(input logic [1:0] w);
        unique case (w)
            `WBC_WIN_25: win_eighths = `WBC_EIGHTHS_25;
            `WBC_WIN_37: win_eighths = `WBC_EIGHTHS_37;
            `WBC_WIN_50: win_eighths = `WBC_EIGHTHS_50;
            default:     win_eighths = `WBC_EIGHTHS_75;
        endcase
    endfunction

    localparam int WIN25_OPEN = (((1 << TICK_BITS) - 1) * 6) / 8;

    wbc_pkg::wbc_state_s_t s_q;
    wbc_pkg::wbc_state_s_t s_d;

    logic [20:0] pre_lim;
    logic [7:0]  cnt_max;
    logic [7:0]  open_at;
    logic        pre_tick;
    logic        clear_req;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_d       = s_q;
        pre_lim   = (21'h000001 << s_q.cfg.ps_code) - 21'h000001;       // see [RULE5]
        cnt_max   = 8'((9'h001 << TICK_BITS) - 9'h001);
        open_at   = 8'((12'(cnt_max) * (12'h008 - 12'(win_eighths(s_q.cfg.win_sel)))) >> 3);
        pre_tick  = (s_q.pre == pre_lim);
        clear_req = WR && (ADDR == `WBC_OFS_CTRL) && WDATA[1];
        s_d.timeout = 1'b0;
        s_d.rdata   = `WBC_RST_ZERO;
        unique case (s_q.st)
            wbc_pkg::WBC_ST_LATCH: begin
                s_d.cfg.win_sel = CFG_WORD[`WBC_WINSZ_HI:`WBC_WINSZ_LO];     // see [RULE8]
                s_d.cfg.hw_en   = CFG_WORD[`WBC_HWEN_BIT];
                s_d.cfg.win_dis = CFG_WORD[`WBC_WINDOW_MODE_DISABLE_BIT];
                s_d.cfg.ps_code = clamp_ps(CFG_WORD[`WBC_PS_HI:`WBC_PS_LO]); // see [RULE6]
                s_d.st          = wbc_pkg::WBC_ST_RUN;                       // see [RULE9]
            end
            wbc_pkg::WBC_ST_RUN: begin
                if (WR && ADDR == `WBC_OFS_CTRL) begin
                    s_d.sw_on = WDATA[0];                                    // see [RULE3]
                end
                s_d.run = s_q.cfg.hw_en || s_d.sw_on;                        // see [RULE2]
                if (!s_q.run) begin
                    s_d.pre = 21'h000000;
                    s_d.cnt = 8'h00;
                end else if (clear_req) begin
                    s_d.early = !s_q.cfg.win_dis && (s_q.cnt < open_at);     // see [RULE4]
                    s_d.timeout = s_d.early;
                    s_d.pre = 21'h000000;
                    s_d.cnt = 8'h00;
                end else if (pre_tick) begin
                    s_d.pre = 21'h000000;
                    if (s_q.cnt == cnt_max) begin
                        s_d.timeout = 1'b1;
                        s_d.cnt = 8'h00;
                    end else begin
                        s_d.cnt = s_q.cnt + 8'h01;
                    end
                end else begin
                    s_d.pre = s_q.pre + 21'h000001;
                end
            end
            default: s_d.st = wbc_pkg::WBC_ST_LATCH;
        endcase
        s_d.wdt_on   = s_d.run;
        s_d.win_open = s_q.run && (s_q.cfg.win_dis || s_q.cnt >= open_at);   // see [RULE1]
        if (RD) begin
            unique case (ADDR)
                `WBC_OFS_CFG:  s_d.rdata = {6'h00, s_q.cfg.win_sel, s_q.cfg.hw_en,
                                            s_q.cfg.win_dis, 1'b0, s_q.cfg.ps_code, 16'h0000};
                `WBC_OFS_CTRL: s_d.rdata = {31'h00000000, s_q.sw_on};
                `WBC_OFS_STAT: s_d.rdata = {28'h0000000, s_q.early, s_q.win_open,
                                            s_q.cfg.hw_en, s_q.run};
                `WBC_OFS_TOUT: s_d.rdata = {24'h000000, s_q.cnt};
                default:       s_d.rdata = `WBC_RST_ZERO;
            endcase
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s_q       <= '0;
            s_q.st    <= wbc_pkg::WBC_ST_LATCH;
        end else begin
            s_q <= s_d;
        end
    end

    assign RDATA       = s_q.rdata;
    assign WDT_ON      = s_q.wdt_on;
    assign WIN_OPEN    = s_q.win_open;
    assign WDT_TIMEOUT = s_q.timeout;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_hw_on;
        @(posedge CLK) disable iff (!RST_N)
        (s_q.st == wbc_pkg::WBC_ST_RUN && s_q.cfg.hw_en) |=> WDT_ON;
    endproperty
    a_hw_on: assert property (p_hw_on) else $error("hw enable not honoured"); // see [RULE2]

    property p_sw_off;
        @(posedge CLK) disable iff (!RST_N)
        (s_q.st == wbc_pkg::WBC_ST_RUN && !s_q.cfg.hw_en && !s_q.sw_on && !WR) |=> !WDT_ON;
    endproperty
    a_sw_off: assert property (p_sw_off) else $error("watchdog on without request"); // see [RULE3]

    property p_sw_start;
        @(posedge CLK) disable iff (!RST_N)
        (s_q.st == wbc_pkg::WBC_ST_RUN && WR && ADDR == `WBC_OFS_CTRL && WDATA[0])
            |=> ##1 WDT_ON;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("software start lost"); // see [RULE3]

    property p_latch;
        @(posedge CLK) disable iff (!RST_N)
        (s_q.st == wbc_pkg::WBC_ST_RUN) |=> $stable(s_q.cfg);
    endproperty
    a_latch: assert property (p_latch) else $error("config changed after reset"); // see [RULE9]

    property p_fields;
        @(posedge CLK) disable iff (!RST_N)
        (s_q.st == wbc_pkg::WBC_ST_LATCH) |=> (s_q.cfg.win_sel == $past(CFG_WORD[25:24])
            && s_q.cfg.hw_en == $past(CFG_WORD[23]) && s_q.cfg.win_dis == $past(CFG_WORD[22]));
    endproperty
    a_fields: assert property (p_fields) else $error("field taken from wrong bits"); // see [RULE8]

    property p_clamp;
        @(posedge CLK) disable iff (!RST_N)
        s_q.cfg.ps_code <= 5'h14;
    endproperty
    a_clamp: assert property (p_clamp) else $error("postscale code above maximum"); // see [RULE6]

    property p_prescale;
        @(posedge CLK) disable iff (!RST_N)
        (s_q.run && pre_tick) |-> (s_q.pre == (21'h000001 << s_q.cfg.ps_code) - 21'h000001);
    endproperty
    a_prescale: assert property (p_prescale) else $error("postscale ratio wrong"); // see [RULE5]

    property p_nowin;
        @(posedge CLK) disable iff (!RST_N)
        (s_q.run && s_q.cfg.win_dis && clear_req) |=> !WDT_TIMEOUT;
    endproperty
    a_nowin: assert property (p_nowin) else $error("early clear punished in normal mode"); // see [RULE4]

    property p_window;
        @(posedge CLK) disable iff (!RST_N)
        (s_q.run && !s_q.cfg.win_dis && s_q.cfg.win_sel == 2'h3 && 32'(s_q.cnt) < WIN25_OPEN)
            |=> !WIN_OPEN;
    endproperty
    a_window: assert property (p_window) else $error("25 percent window opened early"); // see [RULE1]

    c_hw:    cover property (@(posedge CLK) disable iff (!RST_N) s_q.cfg.hw_en && WDT_ON);
    c_early: cover property (@(posedge CLK) disable iff (!RST_N) s_q.early && WDT_TIMEOUT);
    c_open:  cover property (@(posedge CLK) disable iff (!RST_N) $rose(WIN_OPEN));

endmodule

// file: wbc_consts.svh
// constants for the watchdog boot configuration decoder
`ifndef WBC_CONSTS_SVH
`define WBC_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define WBC_OFS_CFG        4'h0
`define WBC_OFS_CTRL       4'h1
`define WBC_OFS_STAT       4'h2
`define WBC_OFS_TOUT       4'h3

// ----------------------------------------
// configuration word fields
// ----------------------------------------
`define WBC_WINSZ_HI       25
`define WBC_WINSZ_LO       24
`define WBC_HWEN_BIT       23
`define WBC_WINDOW_MODE_DISABLE_BIT     22
`define WBC_PS_HI          20
`define WBC_PS_LO          16
`define WBC_PS_MAX         5'h14
`define WBC_RSVD_MASK      32'hFC200000

// ----------------------------------------
// window codes and fractions in eighths
// ----------------------------------------
`define WBC_WIN_25         2'h3
`define WBC_WIN_37         2'h2
`define WBC_WIN_50         2'h1
`define WBC_WIN_75         2'h0
`define WBC_EIGHTHS_25     4'h2
`define WBC_EIGHTHS_37     4'h3
`define WBC_EIGHTHS_50     4'h4
`define WBC_EIGHTHS_75     4'h6

// ----------------------------------------
// reset values
// ----------------------------------------
`define WBC_RST_ZERO       32'h00000000

`endif

// file: wbc_pkg.sv
// types for the watchdog boot configuration decoder
package wbc_pkg;

    typedef enum logic [1:0] {
        WBC_ST_LATCH = 2'h1,
        WBC_ST_RUN   = 2'h2
    } wbc_state_t;

    typedef struct packed {
        logic [1:0] win_sel;
        logic       hw_en;
        logic       win_dis;
        logic [4:0] ps_code;
    } wbc_cfg_t;

    typedef struct packed {
        wbc_state_t  st;
        wbc_cfg_t    cfg;
        logic        sw_on;
        logic [31:0] rdata;
        logic        run;
        logic        wdt_on;
        logic        win_open;
        logic        timeout;
        logic        early;
        logic [20:0] pre;
        logic [7:0]  cnt;
    } wbc_state_s_t;

endpackage

// file: wbc_tb.sv
// self-checking testbench for the watchdog boot configuration decoder
`timescale 1ns/1ps
`include "wbc_consts.svh"

module testbench;
    localparam int TB = 4;
    logic        clk;
    logic        rst_n;
    logic [31:0] cfg_word;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        wdt_on;
    logic        win_open;
    logic        wdt_to;
    int          err_total;
    int          comparisons;
    int          cyc;
    logic [31:0] d;
    logic [31:0] w;
    logic [31:0] cfgs [4] = '{32'hFFE00000, 32'hFE340000, 32'hFDBF0000, 32'hFC610000};

    wbc_top #(.TICK_BITS(TB)) dut_u (.CLK(clk), .RST_N(rst_n), .CFG_WORD(cfg_word), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .WDT_ON(wdt_on), .WIN_OPEN(win_open),
        .WDT_TIMEOUT(wdt_to));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ----------------------------------------
    // bus tasks and checks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic do_reset(input logic [31:0] v);
        @(posedge clk);
        rst_n <= 1'b0;
        cfg_word <= v;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
    endtask
    task automatic first_pulse(input int lim, output int n);
        n = 0;
        #1;
        while (wdt_to !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    function automatic logic [31:0] exp_cfg(input logic [31:0] v);
        logic [4:0] ps;
        ps = (v[20:16] > `WBC_PS_MAX) ? `WBC_PS_MAX : v[20:16];
        return {6'h00, v[25:22], 1'b0, ps, 16'h0000};
    endfunction
    task automatic complete_run;
        $display("counts: %0d mismatches, %0d comparisons", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total++;
            complete_run();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int n;
        cyc = 0;
        err_total = 0;
        comparisons = 0;
        rst_n = 1'b0;
        cfg_word = 32'hFFE00000;
        addr = 4'h0;
        wdata = 32'h00000000;
        wr = 1'b0;
        rd = 1'b0;
        foreach (cfgs[i]) begin
            w = cfgs[i];
            do_reset(w);
            chk("wdt_on_after_reset", {31'h0, w[`WBC_HWEN_BIT]}, {31'h0, wdt_on});
            if (w[`WBC_HWEN_BIT] && w[`WBC_WINDOW_MODE_DISABLE_BIT])
                chk("win_open_nonwin", 32'h1, {31'h0, win_open});
            rd_reg(`WBC_OFS_CFG, d);
            chk("cfg_fields", exp_cfg(w), d);
            cfg_word <= ~w;
            rd_reg(4'hF, d);
            chk("unmapped_read", 32'h0, d);
            wr_reg(`WBC_OFS_CTRL, 32'h0);
            repeat (2) @(posedge clk);
            #1 chk("wdt_on_sw_off", {31'h0, w[`WBC_HWEN_BIT]}, {31'h0, wdt_on});
            wr_reg(`WBC_OFS_CTRL, 32'h1);
            wr_reg(`WBC_OFS_CTRL, 32'h3);
            repeat (2) @(posedge clk);
            #1 chk("wdt_on_sw_on", 32'h1, {31'h0, wdt_on});
            rd_reg(`WBC_OFS_CFG, d);
            chk("cfg_held", exp_cfg(w), d);
            $display("test config %0d done", i);
        end
        // postscale ratio sets the timeout period
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            rst_n <= 1'b0;
            cfg_word <= 32'hFFE00000 | (32'(p) << `WBC_PS_LO);
            repeat (12) @(posedge clk);
            rst_n <= 1'b1;
            first_pulse(200, n);
            chk("timeout_early_bound", 32'h1, {31'h0, n >= (1 << (TB + p)) - 2});
            chk("timeout_late_bound", 32'h1, {31'h0, n <= (1 << (TB + p)) + 8});
            $display("test postscale %0d done", p);
        end
        // windowed mode: a kick before the window opens is an error
        do_reset(32'hFDBF0000);
        chk("win_closed", 32'h0, {31'h0, win_open});
        wr_reg(`WBC_OFS_CTRL, 32'h3);
        first_pulse(4, n);
        chk("early_kick_pulse", 32'h1, {31'h0, wdt_to});
        rd_reg(`WBC_OFS_STAT, d);
        chk("stat_early", 32'h1, {31'h0, d[3]});
        $display("test window done");
        complete_run();
    end
endmodule
